// File: rtl/sie_phase_gen.sv
// Free-running four-phase sequencer of the instruction cycle
`default_nettype none

module sie_phase_gen (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rstSync_b,
  // Phase
  output var  sie_pkg::sie_phase_t phase
);
  import sie_pkg::*;

  // ==========================================================
  // Phase counter
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      phase <= PH_DECODE;
    end else begin
      case (phase)
        PH_DECODE:  phase <= PH_READ;
        PH_READ:    phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE:   phase <= PH_DECODE;
        default:    phase <= PH_DECODE;
      endcase
    end
  end

endmodule // sie_phase_gen

`default_nettype wire

// File: rtl/sie_sub_alu.sv
// Eight-bit subtractor with status flag generation
`default_nettype none

module sie_sub_alu (
  // Operands
  input  wire logic [7:0]     minuend,
  input  wire logic [7:0]     subtrahend,
  // Result
  output logic [7:0]          difference,
  output var  sie_pkg::sie_flags_t flags
);
  import sie_pkg::*;

  logic [8:0] fullSum;
  logic [4:0] lowSum;

  // ==========================================================
  // Subtraction and flags
  always_comb begin
    // [RULE2] two's complement subtract
    fullSum    = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    lowSum     = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    difference = fullSum[7:0];
    // [RULE6] carry means no borrow
    // [RULE8] borrow clears carry
    flags.carry = fullSum[8];
    // [RULE7] zero flag set
    flags.zero  = (fullSum[7:0] == 8'h00);
    // [RULE11] sign, overflow, nibble borrow
    flags.neg             = fullSum[7];
    flags.halfCarryFlag   = lowSum[4];
    flags.signedRangeFlag = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ fullSum[7]);
  end

endmodule // sie_sub_alu

`default_nettype wire

// File: rtl/sie_top.sv
// Execution datapath for the literal and register subtract instructions
`default_nettype none

// Notes on behaviour
// [RULE1] Literal op: accumulator gets the 8-bit literal minus the accumulator.
// [RULE2] Register op: file register minus accumulator, two's complement arithmetic.
// [RULE3] Destination bit 0 writes the accumulator, 1 writes the file register.
// [RULE4] Bank bit 0 selects access bank, 1 uses bank select register.
// [RULE5] Bank bit 0, extension on, field up to 95: indexed offset address.
// [RULE6] Positive difference: carry set, zero and negative cleared; the code takes negative from bit 7 of the difference instead.
// [RULE7] Zero difference: carry set, zero set, negative cleared.
// [RULE8] Borrow: wrapped byte, carry cleared, zero cleared, negative set; the code takes negative from bit 7 of the wrapped byte instead.
// [RULE9] Literal op is one word, one cycle: decode, read, process, write.
// [RULE10] Register op is one word, one cycle: decode, read, process, write.
// [RULE11] Overflow from signed overflow, half carry from bit 3 borrow.
// [RULE12] All flags come from the written subtraction, committed in write phase.
module sie_top (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rst_b,
  // Instruction from the decoder
  input  wire sie_pkg::sie_instr_t instrIn,
  output logic                instrReady,
  output var  sie_pkg::sie_phase_t phase,
  output logic                execDone,
  // Data memory
  output var  sie_pkg::sie_mem_req_t memReq,
  input  wire logic [7:0]     memRdata,
  input  wire logic [11:0]    indexBase,
  // Core state
  output var  sie_pkg::sie_flags_t statusFlags,
  output logic [7:0]          accOut,
  // Software register port
  input  wire logic [3:0]     regAddr,
  input  wire logic [7:0]     regWdata,
  input  wire logic           regWrite,
  input  wire logic           regRead,
  output logic [7:0]          regRdata
);
  import sie_pkg::*;

  // ==========================================================
  // Reset synchroniser
  logic rstMeta_reg;
  logic rstSync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSync_b   <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_b   <= rstMeta_reg;
    end
  end

  // ==========================================================
  // Declarations
  sie_op_t     op_reg;
  logic        dest_reg;
  logic [7:0]  lit_reg;
  logic [7:0]  result_reg;
  sie_flags_t  pend_reg;
  logic [7:0]  acc_reg;
  logic [3:0]  bank_reg;
  logic        ext_reg;
  sie_flags_t  status_reg;
  sie_op_t     decOp;
  logic        accept;
  logic [7:0]  field;
  logic [11:0] decAddr;
  logic [7:0]  minuend;
  logic [7:0]  diff;
  sie_flags_t  aluFlags;

  sie_phase_gen u_phase (
    .clock     (clock),
    .rstSync_b (rstSync_b),
    .phase     (phase)
  );

  // ==========================================================
  // Decode
  assign instrReady = (phase == PH_DECODE);
  assign accept     = instrReady && instrIn.valid && (decOp != OP_NONE);
  assign field      = instrIn.word[FIELD_HI:0];

  always_comb begin
    if (instrIn.word[OPC_HI:LIT_OPC_LO] == LIT_OPCODE) begin
      decOp = OP_LIT;
    end else if (instrIn.word[OPC_HI:REG_OPC_LO] == REG_OPCODE) begin
      decOp = OP_REG;
    end else begin
      decOp = OP_NONE;
    end
  end

  // [RULE4] bank address select
  always_comb begin
    if (instrIn.word[BANK_BIT]) begin
      decAddr = {bank_reg, field};
    // [RULE5] indexed offset mode
    end else if (ext_reg && (field <= INDEX_LIMIT)) begin
      decAddr = indexBase + {4'h0, field};
    end else if (field <= INDEX_LIMIT) begin
      decAddr = {4'h0, field};
    end else begin
      decAddr = ACCESS_HIGH_BASE | {4'h0, field};
    end
  end

  // ==========================================================
  // Instruction latch; only the op is cleared once the write phase is over
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      op_reg   <= OP_NONE;
      dest_reg <= 1'b0;
      lit_reg  <= 8'h00;
    end else if (accept) begin
      op_reg   <= decOp;
      dest_reg <= (decOp == OP_REG) && instrIn.word[DEST_BIT];
      lit_reg  <= field;
    end else if (phase == PH_WRITE) begin
      op_reg   <= OP_NONE;
    end
  end

  // ==========================================================
  // Process phase
  // [RULE1] literal is the minuend
  assign minuend = (op_reg == OP_LIT) ? lit_reg : memRdata;

  sie_sub_alu u_alu (
    .minuend    (minuend),
    .subtrahend (acc_reg),
    .difference (diff),
    .flags      (aluFlags)
  );

  // [RULE12] result and flags held together
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      result_reg <= 8'h00;
      pend_reg   <= FLAGS_RST;
    end else if ((phase == PH_PROCESS) && (op_reg != OP_NONE)) begin
      result_reg <= diff;
      pend_reg   <= aluFlags;
    end
  end

  // ==========================================================
  // Memory requests; read data arrive in the cycle after the read
  // [RULE10] read and write phases
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      memReq <= MEM_REQ_RST;
    end else begin
      memReq.read  <= accept && (decOp == OP_REG);
      memReq.write <= (phase == PH_PROCESS) && (op_reg == OP_REG) && dest_reg;
      if (accept) begin
        memReq.addr <= decAddr;
      end
      if (phase == PH_PROCESS) begin
        memReq.wdata <= diff;
      end
    end
  end

  // [RULE9] done in the write phase
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      execDone <= 1'b0;
    end else begin
      execDone <= (phase == PH_PROCESS) && (op_reg != OP_NONE);
    end
  end

  // ==========================================================
  // Accumulator; an instruction commit wins over a software write
  // [RULE3] accumulator destination
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      acc_reg <= ACC_RST;
    end else if ((phase == PH_WRITE) && (op_reg != OP_NONE) && !dest_reg) begin
      acc_reg <= result_reg;
    end else if (regWrite && (regAddr == ACC_OFS)) begin
      acc_reg <= regWdata;
    end
  end

  // [RULE12] flags commit at write
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      status_reg <= FLAGS_RST;
    end else if ((phase == PH_WRITE) && (op_reg != OP_NONE)) begin
      status_reg <= pend_reg;
    end
  end

  assign statusFlags = status_reg;
  assign accOut      = acc_reg;

  // ==========================================================
  // Software registers
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      bank_reg <= BANK_RST;
      ext_reg  <= EXT_RST;
    end else if (regWrite) begin
      if (regAddr == BANK_OFS) begin
        bank_reg <= regWdata[3:0];
      end
      if (regAddr == CFG_OFS) begin
        ext_reg <= regWdata[CFG_EXT_BIT];
      end
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        BANK_OFS:   regRdata <= {4'h0, bank_reg};
        CFG_OFS:    regRdata <= {7'h00, ext_reg};
        STATUS_OFS: regRdata <= {3'h0, status_reg};
        ACC_OFS:    regRdata <= acc_reg;
        default:    regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ==========================================================
  // Assertions
  wire procLit = (phase == PH_PROCESS) && (op_reg == OP_LIT);
  wire procReg = (phase == PH_PROCESS) && (op_reg == OP_REG);
  wire procAny = (phase == PH_PROCESS) && (op_reg != OP_NONE);

  // [RULE1] literal difference
  litResult_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE1]
    procLit |=> result_reg == $past(lit_reg - acc_reg))
    else $error("literal subtract result wrong");

  // [RULE2] register difference
  regResult_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE2]
    procReg |=> result_reg == $past(memRdata - acc_reg))
    else $error("register subtract result wrong");

  // [RULE3] register destination write
  destWrite_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE3]
    (procReg && dest_reg) |=> memReq.write && (memReq.wdata == result_reg)
      ##1 !memReq.write && (acc_reg == $past(acc_reg)))
    else $error("file register destination not written");

  // [RULE4] banked address
  bankAddr_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE4]
    (accept && (decOp == OP_REG) && instrIn.word[BANK_BIT])
      |=> memReq.read && (memReq.addr == {$past(bank_reg), $past(field)}))
    else $error("banked address wrong");

  // [RULE5] indexed address
  indexAddr_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE5]
    (accept && (decOp == OP_REG) && !instrIn.word[BANK_BIT] && ext_reg
      && (field <= INDEX_LIMIT))
      |=> memReq.addr == $past(indexBase) + {4'h0, $past(field)})
    else $error("indexed address wrong");

  // [RULE6] borrow and zero flags
  carryZero_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE6]
    procAny |=> (pend_reg.carry == ($past(minuend) >= $past(acc_reg)))
      && (pend_reg.zero == ($past(minuend) == $past(acc_reg))))
    else $error("carry or zero flag wrong");

  // [RULE8] negative on borrow
  borrowNeg_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE8]
    (procAny && (minuend < acc_reg)) |=> !pend_reg.carry && !pend_reg.zero
      && (pend_reg.neg == result_reg[7]))
    else $error("borrow flags wrong");

  // [RULE11] signed overflow flag
  overflow_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE11]
    procAny |=> pend_reg.signedRangeFlag ==
      (($past(minuend[7]) != $past(acc_reg[7])) && (result_reg[7] != $past(minuend[7]))))
    else $error("overflow flag wrong");

  // [RULE9] one instruction cycle
  oneCycle_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE9]
    accept |=> ##1 !execDone ##1 execDone ##1 !execDone && (phase == PH_DECODE))
    else $error("instruction did not finish in four phases");

  // [RULE12] flags commit with result
  flagCommit_a: assert property (@(posedge clock) disable iff (!rstSync_b) // [RULE12]
    execDone |=> (status_reg == $past(pend_reg)))
    else $error("flags not committed in write phase");

  litRun_c: cover property (@(posedge clock) disable iff (!rstSync_b)
    accept && (decOp == OP_LIT) ##3 execDone);
  regDest_c: cover property (@(posedge clock) disable iff (!rstSync_b)
    memReq.read ##2 memReq.write);
  borrow_c: cover property (@(posedge clock) disable iff (!rstSync_b)
    execDone && pend_reg.neg && !pend_reg.carry);

endmodule // sie_top

`default_nettype wire

// File: shared/sie_pkg.sv
// Constants and types for the subtract instruction execution block
`default_nettype none

package sie_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int INSTR_W = 16;
  localparam int RADDR_W = 4;
  localparam int BANK_W  = 4;

  // ==========================================================
  // Instruction fields
  localparam int OPC_HI     = 15;
  localparam int LIT_OPC_LO = 8;
  localparam int REG_OPC_LO = 10;
  localparam int DEST_BIT   = 9;
  localparam int BANK_BIT   = 8;
  localparam int FIELD_HI   = 7;
  localparam logic [7:0] LIT_OPCODE = 8'h08;
  localparam logic [5:0] REG_OPCODE = 6'h17;

  // ==========================================================
  // Addressing
  localparam logic [7:0]  INDEX_LIMIT      = 8'h5F;
  localparam logic [11:0] ACCESS_HIGH_BASE = 12'hF00;

  // ==========================================================
  // Software register offsets and reset values
  localparam logic [3:0] BANK_OFS   = 4'h0;
  localparam logic [3:0] CFG_OFS    = 4'h1;
  localparam logic [3:0] STATUS_OFS = 4'h2;
  localparam logic [3:0] ACC_OFS    = 4'h3;
  localparam int         CFG_EXT_BIT = 0;
  localparam logic [3:0] BANK_RST   = 4'h0;
  localparam logic       EXT_RST    = 1'b0;
  localparam logic [7:0] ACC_RST    = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } sie_phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LIT  = 2'b01,
    OP_REG  = 2'b10
  } sie_op_t;

  typedef struct packed {
    logic neg;
    logic signedRangeFlag;
    logic zero;
    logic halfCarryFlag;
    logic carry;
  } sie_flags_t;

  localparam sie_flags_t FLAGS_RST = 5'h00;

  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] word;
  } sie_instr_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sie_mem_req_t;

  localparam sie_mem_req_t MEM_REQ_RST = 22'h000000;

endpackage

`default_nettype wire

// File: verif/sie_mem_model.sv
// Data memory model facing the subtract datapath
`default_nettype none

module sie_mem_model (
  // Clock
  input  wire logic                 clock,
  // Requests from the datapath
  input  wire sie_pkg::sie_mem_req_t memReq,
  // Read data
  output var  logic [7:0]           memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import sie_pkg::*;

  // ==========================================================
  // Storage
  // Plain always so the bench may preload and inspect the array
  logic [7:0] mem [0:4095];

  // Data stand only in the cycle after a read; otherwise they toggle
  always @(posedge clock) begin
    if (memReq.read) begin
      memRdata <= mem[memReq.addr];
    end else begin
      memRdata <= ~memRdata;
    end
    if (memReq.write) begin
      mem[memReq.addr] <= memReq.wdata;
    end
  end
endmodule // sie_mem_model

`default_nettype wire

// File: verif/tb_subtract_instr_exec.sv
// Self-checking testbench for the subtract execution datapath
`default_nettype none

module tb_subtract_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import sie_pkg::*;

  // ==========================================================
  // Signals
  logic         clock     = 1'b0;
  logic         rst_b     = 1'b0;
  sie_instr_t   instrIn   = '0;
  logic         instrReady;
  sie_phase_t   phase;
  logic         execDone;
  sie_mem_req_t memReq;
  logic [7:0]   memRdata;
  logic [11:0]  indexBase = 12'h000;
  sie_flags_t   statusFlags;
  logic [7:0]   accOut;
  logic [3:0]   regAddr   = 4'h0;
  logic [7:0]   regWdata  = 8'h00;
  logic         regWrite  = 1'b0;
  logic         regRead   = 1'b0;
  logic [7:0]   regRdata;
  int           fails     = 0;
  int           n_checks  = 0;
  int           cycles    = 0;

  // ==========================================================
  // Instances
  sie_top u_sie_top (
    .clock(clock), .rst_b(rst_b), .instrIn(instrIn), .instrReady(instrReady),
    .phase(phase), .execDone(execDone), .memReq(memReq), .memRdata(memRdata),
    .indexBase(indexBase), .statusFlags(statusFlags), .accOut(accOut),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata)
  );

  sie_mem_model u_sie_mem_model (.clock(clock), .memReq(memReq), .memRdata(memRdata));

  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #10 clock = ~clock;
  end

  // Generous ceiling; the whole sequence needs under two hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic sie_flags_t subFlags(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] d;
    sie_flags_t f;
    d                 = m - s;
    f.neg             = d[7];
    f.signedRangeFlag = (m[7] != s[7]) && (d[7] != m[7]);
    f.zero            = (d == 8'h00);
    f.halfCarryFlag   = (m[3:0] >= s[3:0]);
    f.carry           = (m >= s);
    return f;
  endfunction

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic regRd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(12'(regRdata), 12'(exp), what);
  endtask

  // Presents a word in Q1 and follows the four phases of its cycle
  task automatic issue(input logic [15:0] word, input logic done, input logic [11:0] addr,
                       input logic rd, input logic wr, input logic [7:0] res);
    // Phase is read settled, never in the time step of the edge that moves it
    do begin
      @(posedge clock);
      #1;
    end while (phase !== PH_WRITE);
    @(posedge clock);
    instrIn <= '{valid: 1'b1, word: word};
    @(posedge clock);
    instrIn.valid <= 1'b0;
    #1;
    chk(12'(instrReady), 12'h000, "ready outside Q1");
    chk(12'(memReq.read), 12'(rd), "read strobe in Q2");
    if (rd) begin
      chk(memReq.addr, addr, "data address");
    end
    @(posedge clock);
    #1;
    chk(12'(execDone), 12'h000, "done early");
    @(posedge clock);
    #1;
    chk(12'(execDone), 12'(done), "done in Q4");
    chk(12'(memReq.write), 12'(wr), "write strobe in Q4");
    if (wr) begin
      chk(12'(memReq.wdata), 12'(res), "write data");
    end
    @(posedge clock);
    #1;
    chk(12'(instrReady), 12'h001, "ready in Q1");
  endtask

  // ==========================================================
  // Scenarios
  task automatic scenReset();
    chk(12'(accOut), 12'h000, "acc after reset");
    regRd(BANK_OFS, 8'h00, "bank after reset");
    regRd(CFG_OFS, 8'h00, "config after reset");
    regRd(4'h7, 8'h00, "unmapped read");
    regWr(STATUS_OFS, 8'hFF);
    regRd(STATUS_OFS, 8'h00, "status is read only");
    regWr(BANK_OFS, 8'h0A);
    regRd(BANK_OFS, 8'h0A, "bank readback");
  endtask

  task automatic scenLiteral();
    logic [7:0] kk [6] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10, 8'hFF};
    logic [7:0] ww [6] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h00};
    logic [7:0] res;
    for (int i = 0; i < 6; i++) begin
      res = kk[i] - ww[i];
      regWr(ACC_OFS, ww[i]);
      issue({LIT_OPCODE, kk[i]}, 1'b1, 12'h000, 1'b0, 1'b0, 8'h00);
      chk(12'(accOut), 12'(res), "literal result");
      chk(12'(statusFlags), 12'(subFlags(kk[i], ww[i])), "flags");
      regRd(STATUS_OFS, 8'(subFlags(kk[i], ww[i])), "status register");
    end
  endtask

  task automatic regCase(input logic d, input logic a, input logic ext, input logic [3:0] bank,
                         input logic [7:0] f, input logic [11:0] base, input logic [7:0] m,
                         input logic [7:0] w, input logic [11:0] addr);
    logic [7:0] res;
    res = m - w;
    u_sie_mem_model.mem[addr] = m;
    regWr(CFG_OFS, {7'h00, ext});
    regWr(BANK_OFS, {4'h0, bank});
    regWr(ACC_OFS, w);
    indexBase <= base;
    issue({REG_OPCODE, d, a, f}, 1'b1, addr, 1'b1, d, res);
    chk(12'(accOut), 12'(d ? w : res), "acc after register op");
    chk(12'(u_sie_mem_model.mem[addr]), 12'(d ? res : m), "file register");
    chk(12'(statusFlags), 12'(subFlags(m, w)), "flags");
  endtask

  task automatic scenIgnored();
    regWr(ACC_OFS, 8'h55);
    issue(16'h0900, 1'b0, 12'h000, 1'b0, 1'b0, 8'h00);
    chk(12'(accOut), 12'h055, "other opcode ignored");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    scenReset();
    scenLiteral();
    regCase(1'b1, 1'b0, 1'b0, 4'h0, 8'h20, 12'h000, 8'h03, 8'h02, 12'h020);
    regCase(1'b0, 1'b0, 1'b0, 4'h0, 8'h80, 12'h000, 8'h02, 8'h02, 12'hF80);
    regCase(1'b1, 1'b1, 1'b0, 4'h5, 8'h33, 12'h000, 8'h01, 8'h02, 12'h533);
    regCase(1'b0, 1'b0, 1'b1, 4'h5, 8'h5F, 12'h100, 8'h90, 8'h10, 12'h15F);
    regCase(1'b1, 1'b0, 1'b1, 4'h5, 8'h60, 12'h100, 8'h00, 8'h01, 12'hF60);
    scenIgnored();
    wrap_up();
  end
endmodule // tb_subtract_instr_exec

`default_nettype wire
